// ---- core/scp_defines.vh ----
/*
  shared constants of the system clock prescaler: register offsets,
  field positions, reset values and the unlock window length.
  assumes an 8-bit register port with byte offsets as printed.
*/
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// register offsets on the register port
`define SCP_ADDR_DIV_CTRL   8'h61
`define SCP_ADDR_OSC_TRIM   8'h66

// clock_divide_control fields
`define SCP_UNLOCK_BIT      7
`define SCP_SEL_MSB         3
`define SCP_SEL_LSB         0

// reset and fuse load values of divide_select, reset value of the trim
`define SCP_SEL_RESET       4'h0
`define SCP_SEL_FUSE_DIV8   4'h3
`define SCP_TRIM_RESET      8'h00

// select codes of note
`define SCP_SEL_MAX_POW2    4'h8
`define SCP_SEL_RC_DIV1     4'hf
// shift used for reserved codes: slowest setting
`define SCP_SHIFT_SLOWEST   4'h9

// unlock window in master cycles
`define SCP_UNLOCK_CYCLES   3'd4

// master edges after reset release until straps are taken
`define SCP_INIT_LAST       2'd2

`endif

// ---- core/scp_sync.v ----
/*
  two flip-flop level synchroniser, parameterised width.
  assumes slowly changing levels (fuses, straps, low rate clocks).
*/
`timescale 1ns/1ps

module scp_sync #(
    parameter W = 1
) (
    input  wire         core_clk_i,
    input  wire         reset_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // first stage feeds only the second stage
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule // scp_sync

// ---- core/scp_clk_div.v ----
/*
  power of two divider producing a one-cycle tick per divided period.
  assumes it runs on the undivided master clock; new shift values are
  taken only at the end of a complete period so no short period occurs.
*/
`timescale 1ns/1ps

module scp_clk_div (
    input  wire       core_clk_i,
    input  wire       reset_i,
    input  wire [3:0] shift_i,
    output wire       tick_o,
    output wire [3:0] shift_o
);

    reg  [8:0] cnt_ff;
    reg  [3:0] shift_ff;
    reg        tick_ff;
    wire [8:0] last_cnt;

    // terminal count of the active period; shift 9 wraps to all ones
    assign last_cnt = (9'h001 << shift_ff) - 9'h001;

    // count is internal only, software has no view of it
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cnt_ff   <= 9'h000;
            shift_ff <= 4'h0;
            tick_ff  <= 1'b0;
        end
        else if (cnt_ff == last_cnt)
        begin
            cnt_ff   <= 9'h000;
            shift_ff <= shift_i; // switch only at a period boundary
            tick_ff  <= 1'b1;
        end
        else
        begin
            cnt_ff  <= cnt_ff + 9'h001;
            tick_ff <= 1'b0;
        end
    end

    assign tick_o  = tick_ff;
    assign shift_o = shift_ff;

endmodule // scp_clk_div

// ---- core/scp_top.v ----
/*
  system clock prescaler with rc oscillator trim register and the
  timer 2 clock source select.
  assumes core_clk_i is the selected, undivided master clock, a simple
  register port (one-cycle strobes, read data one cycle later), and
  fuse/strap inputs that are static after reset.
*/
`timescale 1ns/1ps
`include "scp_defines.vh"

module scp_top (
    input  wire       core_clk_i,
    input  wire       reset_i,
    // register port
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    output wire [7:0] reg_rdata_o,
    // fuses and straps
    input  wire       div8_fuse_i,
    input  wire       rc_osc_sel_i,
    input  wire [7:0] factory_trim_i,
    // timer 2 clock sources
    input  wire       xtal32k_clk_i,
    input  wire       tosc_ext_clk_i,
    input  wire       tmr2_ext_sel_i,
    // divided clock enables and the active divide shift
    output wire       cpu_clk_en_o,
    output wire       flash_clk_en_o,
    output wire       io_clk_en_o,
    output wire       adc_clk_en_o,
    output wire [3:0] div_shift_o,
    // oscillator trim and nvm timing
    output wire [7:0] trim_value_o,
    output wire       trim_range_select_o,
    output wire [6:0] trim_fine_tune_o,
    output wire       nvm_prog_inhibit_o,
    // timer 2 clock
    output wire       tmr2_clk_o,
    output wire       tmr2_tick_o
);

    // synchronised strap and clock inputs
    wire       fuse_div8_s;
    wire       rc_sel_s;
    wire [7:0] factory_trim_s;
    wire       xtal_s;
    wire       tosc_s;
    wire       tmr2_sel_s;

    // register state
    reg  [3:0] divide_select_ff;
    reg  [3:0] nxt_divide_select;
    reg        divide_change_unlock_ff;
    reg        nxt_divide_change_unlock;
    reg  [2:0] unlock_cnt_ff;
    reg  [2:0] nxt_unlock_cnt;
    reg  [7:0] trim_value_ff;
    reg  [7:0] nxt_trim_value;
    reg  [7:0] rdata_ff;
    reg  [7:0] nxt_rdata;

    // init sequencer
    reg  [1:0] init_cnt_ff;
    reg        init_done_ff;
    wire       init_load;

    // divider interface
    reg  [3:0] req_shift;
    wire       div_tick;
    wire [3:0] act_shift;

    // timer 2 clock
    reg        tmr2_clk_ff;
    reg        tmr2_tick_ff;
    wire       tmr2_src;

    // decode
    wire       wr_ctrl;
    wire       wr_trim;
    wire       others_zero;
    wire       unlock_req;
    wire       sel_write;

    // fuse, strap and timer 2 clock levels pass two flops before any use; the register port is used directly
    scp_sync #(
        .W (13)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({div8_fuse_i, rc_osc_sel_i, factory_trim_i,
                      xtal32k_clk_i, tosc_ext_clk_i, tmr2_ext_sel_i}),
        .sync_o     ({fuse_div8_s, rc_sel_s, factory_trim_s,
                      xtal_s, tosc_s, tmr2_sel_s})
    );

    // straps are taken once the synchroniser has filled
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            init_cnt_ff  <= 2'd0;
            init_done_ff <= 1'b0;
        end
        else if (!init_done_ff)
        begin
            init_cnt_ff <= init_cnt_ff + 2'd1;
            if (init_cnt_ff == `SCP_INIT_LAST)
            begin
                init_done_ff <= 1'b1;
            end
        end
    end

    assign init_load = !init_done_ff && (init_cnt_ff == `SCP_INIT_LAST);

    // write decode for the two registers
    assign wr_ctrl     = reg_wr_i && (reg_addr_i == `SCP_ADDR_DIV_CTRL);
    assign wr_trim     = reg_wr_i && (reg_addr_i == `SCP_ADDR_OSC_TRIM);
    assign others_zero = (reg_wdata_i[6:0] == 7'h00);
    assign unlock_req  = wr_ctrl && reg_wdata_i[`SCP_UNLOCK_BIT]
                         && others_zero;
    assign sel_write   = wr_ctrl && !reg_wdata_i[`SCP_UNLOCK_BIT];

    // unlock window and select update
    // a set write ignores everything unless the other bits are zero
    always @*
    begin
        nxt_divide_change_unlock = divide_change_unlock_ff;
        nxt_unlock_cnt           = unlock_cnt_ff;
        nxt_divide_select        = divide_select_ff;
        if (init_load)
        begin
            // fuse decides the start value only
            if (fuse_div8_s)
            begin
                nxt_divide_select = `SCP_SEL_FUSE_DIV8;
            end
            else
            begin
                nxt_divide_select = `SCP_SEL_RESET;
            end
            nxt_divide_change_unlock = 1'b0;
            nxt_unlock_cnt           = 3'd0;
        end
        else if (divide_change_unlock_ff)
        begin
            if (sel_write)
            begin
                // any code is taken, fuse plays no part
                nxt_divide_select        = reg_wdata_i[`SCP_SEL_MSB:`SCP_SEL_LSB];
                nxt_divide_change_unlock = 1'b0;
                nxt_unlock_cnt           = 3'd0;
            end
            else if (unlock_cnt_ff == 3'd1)
            begin
                // rewrites of unlock never reach the counter
                nxt_divide_change_unlock = 1'b0;
                nxt_unlock_cnt           = 3'd0;
            end
            else
            begin
                nxt_unlock_cnt = unlock_cnt_ff - 3'd1;
            end
        end
        else if (unlock_req)
        begin
            nxt_divide_change_unlock = 1'b1;
            nxt_unlock_cnt           = `SCP_UNLOCK_CYCLES;
        end
        // a locked select write falls through unchanged
        else if (sel_write)
        begin
            nxt_divide_select = divide_select_ff;
        end
    end

    // trim register: factory value at init, then software
    always @*
    begin
        nxt_trim_value = trim_value_ff;
        if (init_load)
        begin
            nxt_trim_value = factory_trim_s;
        end
        else if (wr_trim)
        begin
            nxt_trim_value = reg_wdata_i;
        end
    end

    // register state flops
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            divide_select_ff        <= `SCP_SEL_RESET;
            divide_change_unlock_ff <= 1'b0;
            unlock_cnt_ff           <= 3'd0;
            trim_value_ff           <= `SCP_TRIM_RESET;
        end
        else
        begin
            divide_select_ff        <= nxt_divide_select;
            divide_change_unlock_ff <= nxt_divide_change_unlock;
            unlock_cnt_ff           <= nxt_unlock_cnt;
            trim_value_ff           <= nxt_trim_value;
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    // divider count deliberately absent from the map
    always @*
    begin
        nxt_rdata = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `SCP_ADDR_DIV_CTRL:
                begin
                    nxt_rdata = {divide_change_unlock_ff, 3'b000,
                                 divide_select_ff};
                end
                `SCP_ADDR_OSC_TRIM:
                begin
                    nxt_rdata = trim_value_ff;
                end
                default:
                begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    // read data stand one cycle only
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // select code to divide shift; rc adds one extra halving for codes 0 to 8
    // reserved codes go to the slowest rate, the least risky choice
    always @*
    begin
        req_shift = `SCP_SHIFT_SLOWEST;
        if (divide_select_ff <= `SCP_SEL_MAX_POW2)
        begin
            if (rc_sel_s)
            begin
                req_shift = divide_select_ff + 4'h1;
            end
            else
            begin
                req_shift = divide_select_ff;
            end
        end
        else if (divide_select_ff == `SCP_SEL_RC_DIV1)
        begin
            // also divides by one off rc; software must not rely on it
            req_shift = 4'h0;
        end
        else
        begin
            req_shift = `SCP_SHIFT_SLOWEST;
        end
    end

    // divider on the undivided master clock, any source
    // change taken at a period end, so old period completes first
    scp_clk_div u_div (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .shift_i    (req_shift),
        .tick_o     (div_tick),
        .shift_o    (act_shift)
    );

    // one tick feeds every synchronous domain
    assign cpu_clk_en_o   = div_tick;
    assign flash_clk_en_o = div_tick;
    assign io_clk_en_o    = div_tick;
    assign adc_clk_en_o   = div_tick;
    assign div_shift_o    = act_shift;

    // trim fields drive the oscillator and nvm write timer
    assign trim_value_o        = trim_value_ff;
    assign trim_range_select_o = trim_value_ff[7];
    assign trim_fine_tune_o    = trim_value_ff[6:0];

    // nvm programming is blocked in the fastest rc setting
    assign nvm_prog_inhibit_o = rc_sel_s
                                && (divide_select_ff == `SCP_SEL_RC_DIV1);

    // timer 2 source: crystal or external pin, sampled at master rate
    assign tmr2_src = tmr2_sel_s ? tosc_s : xtal_s;

    // rising edge detect on the synchronised source
    // resolution limited to one master cycle, fine for 32 kHz
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tmr2_clk_ff  <= 1'b0;
            tmr2_tick_ff <= 1'b0;
        end
        else
        begin
            tmr2_clk_ff  <= tmr2_src;
            tmr2_tick_ff <= tmr2_src && !tmr2_clk_ff;
        end
    end

    assign tmr2_clk_o  = tmr2_clk_ff;
    assign tmr2_tick_o = tmr2_tick_ff;

endmodule // scp_top

// ---- tb/scp_top_sva.sv ----
/*
  checker for the system clock prescaler top: register port, divider
  period and unlock window relations.
  assumes one clock, asynchronous active-high reset, bound by bind.
*/
`timescale 1ns/1ps

module scp_top_sva (
    input wire       core_clk_i,
    input wire       reset_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_wr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       rc_osc_sel_i,
    input wire       cpu_clk_en_o,
    input wire       flash_clk_en_o,
    input wire       io_clk_en_o,
    input wire       adc_clk_en_o,
    input wire [3:0] div_shift_o,
    input wire [7:0] trim_value_o,
    input wire       trim_range_select_o,
    input wire [6:0] trim_fine_tune_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    reg  [2:0] win_ff;
    reg  [9:0] gap_ff;
    reg  [3:0] shf_ff;
    reg  [3:0] code_ff;
    reg        seen_ff;
    wire       wr_ctl = reg_wr_i && reg_addr_i == 8'h61;

    function [3:0] smap(input [3:0] c, input rc);
        smap = (c <= 4'h8) ? c + {3'h0, rc} : ((c == 4'hf) ? 4'h0 : 4'h9);
    endfunction

    // shadow of the unlock window and the tick spacing
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            win_ff  <= 3'h0;
            gap_ff  <= 10'h000;
            shf_ff  <= 4'h0;
            code_ff <= 4'h0;
            seen_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctl && reg_wdata_i == 8'h80 && win_ff == 3'h0)
                win_ff <= 3'h4;
            else if (wr_ctl && !reg_wdata_i[7])
                win_ff <= 3'h0;
            else if (win_ff != 3'h0)
                win_ff <= win_ff - 3'h1;
            if (wr_ctl && !reg_wdata_i[7] && win_ff != 3'h0)
                code_ff <= reg_wdata_i[3:0];
            gap_ff <= cpu_clk_en_o ? 10'h000 : gap_ff + 10'h001;
            if (cpu_clk_en_o)
            begin
                shf_ff  <= div_shift_o;
                seen_ff <= 1'b1;
            end
        end
    end

    AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_EN_SAME: assert property (cpu_clk_en_o == flash_clk_en_o &&
        cpu_clk_en_o == io_clk_en_o && cpu_clk_en_o == adc_clk_en_o)
        else $error("clock enables differ");
    AST_TRIM_BITS: assert property (trim_range_select_o == trim_value_o[7] &&
        trim_fine_tune_o == trim_value_o[6:0]) else $error("trim fields split wrong");
    AST_TRIM_WR: assert property (reg_wr_i && reg_addr_i == 8'h66 |=>
        trim_value_o == $past(reg_wdata_i)) else $error("trim write lost");
    AST_UNLOCK_RD: assert property (reg_rd_i && reg_addr_i == 8'h61 |=>
        reg_rdata_o[7:4] == {($past(win_ff) != 3'h0), 3'h0}) else $error("unlock bit wrong");
    AST_LOCKED: assert property (wr_ctl && !reg_wdata_i[7] && win_ff == 3'h0 |=>
        $stable(div_shift_o) [*8]) else $error("locked write changed divider");
    AST_TAKE: assert property (wr_ctl && !reg_wdata_i[7] && win_ff != 3'h0 |=>
        ##[0:600] div_shift_o == smap(code_ff, rc_osc_sel_i)) else $error("new division not taken");
    AST_PERIOD: assert property (cpu_clk_en_o && seen_ff && shf_ff == div_shift_o &&
        $past(div_shift_o) == div_shift_o |-> gap_ff == (10'h1 << div_shift_o) - 10'h1)
        else $error("divided period wrong");
    AST_SWITCH: assert property (cpu_clk_en_o && seen_ff && shf_ff != div_shift_o
        |-> gap_ff == (10'h1 << shf_ff) - 10'h1) else $error("old period cut short");
endmodule // scp_top_sva

bind scp_top scp_top_sva scp_top_sva_inst (
    .core_clk_i          (core_clk_i),
    .reset_i             (reset_i),
    .reg_addr_i          (reg_addr_i),
    .reg_wdata_i         (reg_wdata_i),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_rdata_o         (reg_rdata_o),
    .rc_osc_sel_i        (rc_osc_sel_i),
    .cpu_clk_en_o        (cpu_clk_en_o),
    .flash_clk_en_o      (flash_clk_en_o),
    .io_clk_en_o         (io_clk_en_o),
    .adc_clk_en_o        (adc_clk_en_o),
    .div_shift_o         (div_shift_o),
    .trim_value_o        (trim_value_o),
    .trim_range_select_o (trim_range_select_o),
    .trim_fine_tune_o    (trim_fine_tune_o)
);

// ---- tb/system_clock_prescaler_tb_top.sv ----
/*
  directed testbench for the system clock prescaler top.
  assumes the checker is attached by bind and a 50 MHz clock.
*/
`timescale 1ns/1ps

module system_clock_prescaler_tb_top;
    reg        core_clk_i = 1'b0;
    reg        reset_i = 1'b1;
    reg        reg_wr_i = 1'b0;
    reg        reg_rd_i = 1'b0;
    reg        div8_fuse_i = 1'b1;
    reg        rc_osc_sel_i = 1'b0;
    reg        xtal32k_clk_i = 1'b0;
    reg        tosc_ext_clk_i = 1'b0;
    reg        tmr2_ext_sel_i = 1'b0;
    reg  [7:0] reg_addr_i = 8'h00;
    reg  [7:0] reg_wdata_i = 8'h00;
    reg  [7:0] factory_trim_i = 8'h5a;
    reg  [7:0] d;
    wire [7:0] reg_rdata_o;
    wire [7:0] trim_value_o;
    wire [6:0] trim_fine_tune_o;
    wire [3:0] div_shift_o;
    wire       cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o;
    wire       trim_range_select_o, nvm_prog_inhibit_o, tmr2_clk_o, tmr2_tick_o;
    integer    mismatches = 0;
    integer    comparisons = 0;

    scp_top scp_top_inst (
        .core_clk_i          (core_clk_i),
        .reset_i             (reset_i),
        .reg_addr_i          (reg_addr_i),
        .reg_wdata_i         (reg_wdata_i),
        .reg_wr_i            (reg_wr_i),
        .reg_rd_i            (reg_rd_i),
        .reg_rdata_o         (reg_rdata_o),
        .div8_fuse_i         (div8_fuse_i),
        .rc_osc_sel_i        (rc_osc_sel_i),
        .factory_trim_i      (factory_trim_i),
        .xtal32k_clk_i       (xtal32k_clk_i),
        .tosc_ext_clk_i      (tosc_ext_clk_i),
        .tmr2_ext_sel_i      (tmr2_ext_sel_i),
        .cpu_clk_en_o        (cpu_clk_en_o),
        .flash_clk_en_o      (flash_clk_en_o),
        .io_clk_en_o         (io_clk_en_o),
        .adc_clk_en_o        (adc_clk_en_o),
        .div_shift_o         (div_shift_o),
        .trim_value_o        (trim_value_o),
        .trim_range_select_o (trim_range_select_o),
        .trim_fine_tune_o    (trim_fine_tune_o),
        .nvm_prog_inhibit_o  (nvm_prog_inhibit_o),
        .tmr2_clk_o          (tmr2_clk_o),
        .tmr2_tick_o         (tmr2_tick_o)
    );

    // 20 ns master clock
    always #10 core_clk_i = ~core_clk_i;

    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input [7:0] got, input [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task idle(input integer n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // strobes drop on the sampling edge, so two writes sit two edges apart
    task wr(input [7:0] a, input [7:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task rd(input [7:0] a);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    function [3:0] smap(input [3:0] c, input rc);
        smap = (c <= 4'h8) ? c + {3'h0, rc} : ((c == 4'hf) ? 4'h0 : 4'h9);
    endfunction

    // bounded wait: 700 edges, beyond the longest old period of 512
    task settle(input [3:0] e);
        integer i;
        // look just after the edge, once the divider has settled
        for (i = 0; i < 700 && div_shift_o !== e; i = i + 1)
        begin
            @(posedge core_clk_i);
            #1;
        end
        chk({4'h0, div_shift_o}, {4'h0, e});
    endtask

    task t_reset(input f, input r);
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        div8_fuse_i <= f;
        rc_osc_sel_i <= r;
        idle(8);
        reset_i <= 1'b0;
        idle(4);
        rd(8'h61);
        chk(d, f ? 8'h03 : 8'h00);
        rd(8'h66);
        chk(d, 8'h5a);
        settle(smap(f ? 4'h3 : 4'h0, r));
    endtask

    // unlock window: bad unlock, timeout, rewrite inside the window
    task t_unlock;
        wr(8'h61, 8'h80);
        rd(8'h61);
        chk(d, 8'h83);
        wr(8'h61, 8'h05);
        rd(8'h61);
        chk(d, 8'h05);
        settle(4'h5);
        wr(8'h61, 8'h81);
        wr(8'h61, 8'h02);
        rd(8'h61);
        chk(d, 8'h05);
        wr(8'h61, 8'h80);
        idle(3);
        wr(8'h61, 8'h02);
        rd(8'h61);
        chk(d, 8'h05);
        wr(8'h61, 8'h80);
        wr(8'h61, 8'h80);
        wr(8'h61, 8'h01);
        rd(8'h61);
        chk(d, 8'h01);
        settle(4'h1);
        wr(8'h61, 8'h80);
        idle(1);
        wr(8'h61, 8'h80);
        wr(8'h61, 8'h02);
        rd(8'h61);
        chk(d, 8'h01);
    endtask

    task t_codes(input r);
        integer c;
        for (c = 0; c < 16; c = c + 1)
        begin
            wr(8'h61, 8'h80);
            wr(8'h61, c[7:0]);
            settle(smap(c[3:0], r));
            rd(8'h61);
            chk(d, c[7:0]);
            chk({7'h0, nvm_prog_inhibit_o}, {7'h0, r && c == 15});
        end
    endtask

    // range boundaries of the trim, plus an unmapped place
    task t_trim;
        reg [7:0] v [0:2];
        integer i;
        v[0] = 8'h7f;
        v[1] = 8'h80;
        v[2] = 8'hff;
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(8'h66, v[i]);
            chk({trim_range_select_o, trim_fine_tune_o}, v[i]);
            rd(8'h66);
            chk(d, v[i]);
        end
        wr(8'h70, 8'h11);
        rd(8'h70);
        chk(d, 8'h00);
        chk(trim_value_o, 8'hff);
    endtask

    // crystal edge gives one tick, then the pin path after the switch
    task t_tmr2;
        @(posedge core_clk_i);
        xtal32k_clk_i <= 1'b1;
        idle(3);
        #1;
        chk({6'h0, tmr2_clk_o, tmr2_tick_o}, 8'h03);
        idle(3);
        #1;
        chk({6'h0, tmr2_clk_o, tmr2_tick_o}, 8'h02);
        @(posedge core_clk_i);
        tmr2_ext_sel_i <= 1'b1;
        idle(6);
        #1;
        chk({6'h0, tmr2_clk_o, tmr2_tick_o}, 8'h00);
        @(posedge core_clk_i);
        tosc_ext_clk_i <= 1'b1;
        idle(3);
        #1;
        chk({6'h0, tmr2_clk_o, tmr2_tick_o}, 8'h03);
    endtask

    initial
    begin
        t_reset(1'b1, 1'b0);
        t_unlock;
        t_trim;
        t_tmr2;
        t_reset(1'b0, 1'b0);
        t_codes(1'b0);
        t_reset(1'b1, 1'b1);
        t_codes(1'b1);
        conclude;
    end

    // watchdog well beyond the longest expected run
    initial
    begin
        #1000000;
        mismatches = mismatches + 1;
        conclude;
    end
endmodule // system_clock_prescaler_tb_top
